// ===== logic/pscv_top.sv
// shutdown-cause, die status and controller voltage-code register bank
`timescale 1ns/1ps
`default_nettype none
module pscv_top #(
    parameter logic [7:0]  CTRL1_RESET  = 8'h00,    // factory value of controller 1 register
    parameter logic [7:0]  CTRL2_RESET  = 8'h00,    // factory value of controller 2 register
    parameter logic        WIDE_RANGE1  = 1'b0,     // controller 1 step range
    parameter logic        WIDE_RANGE2  = 1'b0,     // controller 2 step range
    parameter logic [15:0] BASE_FINE_MV = 16'h0000, // code 0 voltage, fine range
    parameter logic [15:0] BASE_WIDE_MV = 16'h0000  // code 0 voltage, wide range
) (
    input  wire logic                sys_clk,
    input  wire logic                rst_b,
    input  wire pscv_pkg::pscv_byte_t reg_addr,
    input  wire logic                reg_wr_en,
    input  wire logic                reg_rd_en,
    input  wire pscv_pkg::pscv_byte_t reg_wdata,
    output var  pscv_pkg::pscv_byte_t reg_rdata,
    input  wire logic                die_hot_pin,
    input  wire logic                uv_trip_pin,
    input  wire logic                power_fault_cause_pin,
    input  wire logic                power_fault_cause_mask_pin,
    input  wire logic                crit_temp_pin,
    input  wire logic [15:0]         fault_rail_pins,
    output var  logic                shutdown_indicator,
    output var  pscv_pkg::pscv_mv_t  ctrl1_target_mv,
    output var  logic                ctrl1_slew_down,
    output var  logic                ctrl1_decay_down,
    output var  pscv_pkg::pscv_mv_t  ctrl2_target_mv,
    output var  logic                ctrl2_slew_down,
    output var  logic                ctrl2_decay_down
);
    import pscv_pkg::*;
`include "pscv_regs.svh"

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    // order: mask, crit, fault, uv, die hot
    logic [4:0]  pin_s1_q;      // first stage, read only by the second
    logic [4:0]  pin_s2_q;      // synchronised levels
    logic [4:0]  pin_s3_q;      // previous level for edge detection
    logic [15:0] rail_s1_q;     // first stage of rail fault flags
    logic [15:0] rail_s2_q;     // synchronised rail fault flags
    logic [4:0]  pin_raw;       // packed pin levels

    assign pin_raw = {power_fault_cause_mask_pin, crit_temp_pin, power_fault_cause_pin, uv_trip_pin,
                      die_hot_pin};

    // two flops before any logic; the third only serves the edge detect
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_s1_q  <= 5'h00;
            pin_s2_q  <= 5'h00;
            pin_s3_q  <= 5'h00;
            rail_s1_q <= 16'h0000;
            rail_s2_q <= 16'h0000;
        end
        else
        begin
            pin_s1_q  <= pin_raw;
            pin_s2_q  <= pin_s1_q;
            pin_s3_q  <= pin_s2_q;
            rail_s1_q <= fault_rail_pins;
            rail_s2_q <= rail_s1_q;
        end
    end

    // ****************************************************************
    // shutdown events
    // ****************************************************************
    logic die_hot;      // synchronised die hot level
    logic uv_evt;       // undervoltage shutdown, one cycle
    logic pf_evt;       // unmasked power fault shutdown, one cycle
    logic ct_evt;       // critical temperature shutdown, one cycle
    logic any_evt;      // any cause set this cycle

    assign die_hot = pin_s2_q[0];
    assign uv_evt  = pin_s2_q[1] & ~pin_s3_q[1];
    // a masked fault never shuts the device down, so it records nothing
    assign pf_evt  = pin_s2_q[2] & ~pin_s3_q[2] & ~pin_s2_q[4];
    assign ct_evt  = pin_s2_q[3] & ~pin_s3_q[3];
    assign any_evt = uv_evt | pf_evt | ct_evt;

    // ****************************************************************
    // address decode
    // ****************************************************************
    pscv_sel_t sel;     // register selected by the offset
    logic      wr_cause; // write strobe, cause register
    logic      wr_irq;   // write strobe, interrupt register
    logic      wr_ctrl1; // write strobe, controller 1
    logic      wr_ctrl2; // write strobe, controller 2

    assign sel = (reg_addr == `PSCV_OFS_IRQ)     ? PSCV_SEL_IRQ     :
                 (reg_addr == `PSCV_OFS_STATUS)  ? PSCV_SEL_STATUS  :
                 (reg_addr == `PSCV_OFS_CAUSE)   ? PSCV_SEL_CAUSE   :
                 (reg_addr == `PSCV_OFS_CTRL1)   ? PSCV_SEL_CTRL1   :
                 (reg_addr == `PSCV_OFS_CTRL2)   ? PSCV_SEL_CTRL2   :
                 (reg_addr == `PSCV_OFS_FSRC_LO) ? PSCV_SEL_FSRC_LO :
                 (reg_addr == `PSCV_OFS_FSRC_HI) ? PSCV_SEL_FSRC_HI : PSCV_SEL_NONE;

    // status and fault-source registers have no write strobe at all
    assign wr_cause = reg_wr_en && (sel == PSCV_SEL_CAUSE);
    assign wr_irq   = reg_wr_en && (sel == PSCV_SEL_IRQ);
    assign wr_ctrl1 = reg_wr_en && (sel == PSCV_SEL_CTRL1);
    assign wr_ctrl2 = reg_wr_en && (sel == PSCV_SEL_CTRL2);

    // ****************************************************************
    // shutdown cause and indicator
    // ****************************************************************
    logic [2:0]  cause_q;   // {uv, pf, ct}; cold-off is not stored
    logic [2:0]  cause_set; // bits set by hardware this cycle
    logic [2:0]  cause_clr; // bits cleared by host this cycle
    logic [2:0]  cause_d;   // next cause value
    logic        ind_clr;   // host clears the indicator
    logic        ind_d;     // next indicator value
    logic [15:0] fsrc_q;    // rail that caused the last fault shutdown

    assign cause_set = {uv_evt, pf_evt, ct_evt};
    // only ones clear; zeros leave the bit alone
    assign cause_clr = wr_cause ? reg_wdata[2:0] : 3'h0;
    // set wins over a clear in the same cycle so no shutdown is lost
    assign cause_d   = (cause_q & ~cause_clr) | cause_set;
    // the indicator only lets go once every cause has been cleared
    assign ind_clr   = wr_irq && reg_wdata[`PSCV_BIT_SD_IND] && (cause_q == 3'h0);
    assign ind_d     = (shutdown_indicator && !ind_clr) || any_evt;

    // sticky flags and the fault-source snapshot
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cause_q            <= `PSCV_CAUSE_RST;
            shutdown_indicator <= `PSCV_IRQ_RST;
            fsrc_q             <= `PSCV_FSRC_RST;
        end
        else
        begin
            cause_q            <= cause_d;
            shutdown_indicator <= ind_d;
            if (pf_evt)
            begin
                fsrc_q <= rail_s2_q;
            end
        end
    end

    // ****************************************************************
    // controller voltage registers
    // ****************************************************************
    pscv_byte_t ctrl1_q; // controller 1 code and decay
    pscv_byte_t ctrl2_q; // controller 2 code and decay

    // factory value arrives through the parameter, a constant at reset
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl1_q <= CTRL1_RESET;
            ctrl2_q <= CTRL2_RESET;
        end
        else
        begin
            if (wr_ctrl1)
            begin
                ctrl1_q <= reg_wdata;
            end
            if (wr_ctrl2)
            begin
                ctrl2_q <= reg_wdata;
            end
        end
    end

    // ****************************************************************
    // regulator hand-off
    // ****************************************************************
    pscv_vid_if vid1 ();
    pscv_vid_if vid2 ();

    // load follows the register write so the target sees the new code
    assign vid1.code  = ctrl1_q[`PSCV_CODE_MSB:`PSCV_CODE_LSB];
    assign vid1.decay = ctrl1_q[`PSCV_BIT_DECAY];
    assign vid2.code  = ctrl2_q[`PSCV_CODE_MSB:`PSCV_CODE_LSB];
    assign vid2.decay = ctrl2_q[`PSCV_BIT_DECAY];

    logic load1_q; // write to controller 1 seen one cycle ago
    logic load2_q; // write to controller 2 seen one cycle ago

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            load1_q <= 1'b0;
            load2_q <= 1'b0;
        end
        else
        begin
            load1_q <= wr_ctrl1;
            load2_q <= wr_ctrl2;
        end
    end

    assign vid1.load = load1_q;
    assign vid2.load = load2_q;

    // controller 1 conversion and down-step mode
    pscv_vid_ctrl #(
        .WIDE_RANGE   (WIDE_RANGE1),
        .BASE_FINE_MV (BASE_FINE_MV),
        .BASE_WIDE_MV (BASE_WIDE_MV),
        .RESET_CODE   (CTRL1_RESET[7:1])
    ) u_vid1 (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .vid        (vid1.sink),
        .target_mv  (ctrl1_target_mv),
        .slew_down  (ctrl1_slew_down),
        .decay_down (ctrl1_decay_down)
    );

    // controller 2 conversion and down-step mode
    pscv_vid_ctrl #(
        .WIDE_RANGE   (WIDE_RANGE2),
        .BASE_FINE_MV (BASE_FINE_MV),
        .BASE_WIDE_MV (BASE_WIDE_MV),
        .RESET_CODE   (CTRL2_RESET[7:1])
    ) u_vid2 (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .vid        (vid2.sink),
        .target_mv  (ctrl2_target_mv),
        .slew_down  (ctrl2_slew_down),
        .decay_down (ctrl2_decay_down)
    );

    // ****************************************************************
    // read path
    // ****************************************************************
    pscv_byte_t rd_mux; // value of the selected register

    // reserved bits and the cold-off bit are tied to zero here
    assign rd_mux = (sel == PSCV_SEL_IRQ)     ? {4'h0, shutdown_indicator, 3'h0} :
                    (sel == PSCV_SEL_STATUS)  ? {7'h00, die_hot}             :
                    (sel == PSCV_SEL_CAUSE)   ? {5'h00, cause_q}             :
                    (sel == PSCV_SEL_CTRL1)   ? ctrl1_q                      :
                    (sel == PSCV_SEL_CTRL2)   ? ctrl2_q                      :
                    (sel == PSCV_SEL_FSRC_LO) ? fsrc_q[7:0]                  :
                    (sel == PSCV_SEL_FSRC_HI) ? fsrc_q[15:8]                 : 8'h00;

    // read data is registered and holds until the next read
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd_en)
        begin
            reg_rdata <= rd_mux;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence seq_status_read;
        reg_rd_en && (sel == PSCV_SEL_STATUS);
    endsequence
    sequence seq_clean_clear(int b);
        wr_cause && reg_wdata[b] && !cause_set[b];
    endsequence

    AST_DIE_HOT: assert property (@(posedge sys_clk) disable iff (!rst_b)
        seq_status_read |=> reg_rdata == {7'h00, $past(die_hot)})
        else $error("status read does not show die hot level");
    AST_CAUSE_RSVD: assert property (@(posedge sys_clk) disable iff (!rst_b)
        reg_rd_en && (sel == PSCV_SEL_CAUSE) |=> reg_rdata[7:3] == 5'h00)
        else $error("reserved or cold-off cause bit reads one");
    AST_W1C: assert property (@(posedge sys_clk) disable iff (!rst_b)
        seq_clean_clear(`PSCV_BIT_UV) |=> !cause_q[`PSCV_BIT_UV])
        else $error("write of one did not clear undervoltage cause");
    AST_W0_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_cause && !reg_wdata[0] && cause_q[0] |=> cause_q[0])
        else $error("write of zero cleared a cause bit");
    AST_UV_SET: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(pin_s2_q[1]) |=> cause_q[`PSCV_BIT_UV])
        else $error("undervoltage shutdown not recorded");
    AST_PF_SET: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(pin_s2_q[2]) && !pin_s2_q[4] |=> cause_q[`PSCV_BIT_PF] && (fsrc_q == $past(rail_s2_q)))
        else $error("unmasked power fault not recorded with its rail");
    AST_CT_SET: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(pin_s2_q[3]) |=> cause_q[`PSCV_BIT_CT])
        else $error("critical temperature shutdown not recorded");
    AST_IND_SET: assert property (@(posedge sys_clk) disable iff (!rst_b)
        any_evt |=> shutdown_indicator [*1] ##0 (cause_q != 3'h0))
        else $error("cause set without shutdown indicator");
    AST_IND_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_irq && (cause_q != 3'h0) && shutdown_indicator |=> shutdown_indicator)
        else $error("indicator cleared while causes still set");
    AST_CTRL_WR: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wr_ctrl1 |=> (ctrl1_q == $past(reg_wdata)) && vid1.load)
        else $error("controller 1 write not stored or not handed on");
endmodule : pscv_top
`default_nettype wire

// ===== logic/pscv_regs.svh
// register offsets, field positions and reset values of the shutdown-cause and voltage-code bank
`ifndef PSCV_REGS_SVH
`define PSCV_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define PSCV_OFS_IRQ       8'h02
`define PSCV_OFS_STATUS    8'h04
`define PSCV_OFS_CAUSE     8'h05
`define PSCV_OFS_CTRL1     8'h20
`define PSCV_OFS_CTRL2     8'h21
`define PSCV_OFS_FSRC_LO   8'hB2
`define PSCV_OFS_FSRC_HI   8'hB3

// ****************************************************************
// field positions
// ****************************************************************
`define PSCV_BIT_DIE_HOT   0
`define PSCV_BIT_SD_IND    3
`define PSCV_BIT_COLD      3
`define PSCV_BIT_UV        2
`define PSCV_BIT_PF        1
`define PSCV_BIT_CT        0
`define PSCV_BIT_DECAY     0
`define PSCV_CODE_MSB      7
`define PSCV_CODE_LSB      1

// ****************************************************************
// reset values and step sizes
// ****************************************************************
`define PSCV_CAUSE_RST     3'h0
`define PSCV_IRQ_RST       1'b0
`define PSCV_FSRC_RST      16'h0000
`define PSCV_STEP_FINE_MV  16'h000A
`define PSCV_STEP_WIDE_MV  16'h0019

`endif

// ===== logic/pscv_pkg.sv
// shared types of the shutdown-cause and voltage-code bank
package pscv_pkg;
    typedef logic [7:0]  pscv_byte_t;   // one register byte
    typedef logic [6:0]  pscv_code_t;   // regulator voltage code
    typedef logic [15:0] pscv_mv_t;     // voltage in millivolts
    // register select decoded from the offset
    typedef enum logic [2:0] {
        PSCV_SEL_NONE    = 3'b000,
        PSCV_SEL_IRQ     = 3'b001,
        PSCV_SEL_STATUS  = 3'b010,
        PSCV_SEL_CAUSE   = 3'b011,
        PSCV_SEL_CTRL1   = 3'b100,
        PSCV_SEL_CTRL2   = 3'b101,
        PSCV_SEL_FSRC_LO = 3'b110,
        PSCV_SEL_FSRC_HI = 3'b111
    } pscv_sel_t;
endpackage : pscv_pkg

// ===== logic/pscv_vid_if.sv
// carrier of one regulator's voltage code and decay setting
`timescale 1ns/1ps
`default_nettype none
interface pscv_vid_if;
    import pscv_pkg::*;
    pscv_code_t code;   // voltage code held in the control register
    logic       decay;  // passive decay selected
    logic       load;   // one-cycle pulse when software wrote the register
    modport src  (output code, output decay, output load);
    modport sink (input code, input decay, input load);
endinterface : pscv_vid_if
`default_nettype wire

// ===== logic/pscv_vid_ctrl.sv
// voltage-code to target conversion and down-step behaviour for one controller
`timescale 1ns/1ps
`default_nettype none
module pscv_vid_ctrl #(
    parameter logic        WIDE_RANGE   = 1'b0,     // factory step range: 0 fine, 1 wide
    parameter logic [15:0] BASE_FINE_MV = 16'h0000, // voltage of code 0, fine range
    parameter logic [15:0] BASE_WIDE_MV = 16'h0000, // voltage of code 0, wide range
    parameter logic [6:0]  RESET_CODE   = 7'h00     // factory code loaded at reset
) (
    input  wire logic           sys_clk,
    input  wire logic           rst_b,
    pscv_vid_if.sink            vid,
    output var  pscv_pkg::pscv_mv_t target_mv,
    output var  logic           slew_down,
    output var  logic           decay_down
);
    import pscv_pkg::*;
`include "pscv_regs.svh"

    // ****************************************************************
    // code conversion
    // ****************************************************************
    // one code maps to base plus code times the selected step
    function automatic pscv_mv_t code_to_mv(input pscv_code_t c);
        pscv_mv_t step;
        pscv_mv_t base;
        step = WIDE_RANGE ? `PSCV_STEP_WIDE_MV : `PSCV_STEP_FINE_MV;
        base = WIDE_RANGE ? BASE_WIDE_MV : BASE_FINE_MV;
        return base + ({9'h000, c} * step);
    endfunction : code_to_mv

    pscv_mv_t new_mv;   // target of the code just written
    logic     going_down; // new target below the present one

    assign new_mv     = code_to_mv(vid.code);
    assign going_down = vid.load && (new_mv < target_mv);

    // ****************************************************************
    // target and down-step mode
    // ****************************************************************
    // mode flags hold until the next write so the regulator sees a level
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            target_mv  <= code_to_mv(RESET_CODE);
            slew_down  <= 1'b0;
            decay_down <= 1'b0;
        end
        else if (vid.load)
        begin
            target_mv  <= new_mv;
            slew_down  <= going_down && !vid.decay;
            decay_down <= going_down && vid.decay;
        end
    end

    // decay picks passive discharge, never an active pull-down
    AST_DOWN_MODE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        going_down |=> (decay_down == $past(vid.decay)) && (slew_down != decay_down))
        else $error("down-step mode does not follow the decay bit");
endmodule : pscv_vid_ctrl
`default_nettype wire

// ===== tb/pscv_host.sv
// host register master model driving the bank's register port
`timescale 1ns/1ps
`default_nettype none
module pscv_host (
    input  wire logic                 sys_clk,
    output var  pscv_pkg::pscv_byte_t reg_addr,
    output var  logic                 reg_wr_en,
    output var  logic                 reg_rd_en,
    output var  pscv_pkg::pscv_byte_t reg_wdata,
    input  wire pscv_pkg::pscv_byte_t reg_rdata
);
    import pscv_pkg::*;
    // idle bus from time zero, both strobes low
    initial
    begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
    end
    // one write; released lines are inverted so stale values never look valid
    task automatic wr(input pscv_byte_t a, input pscv_byte_t d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr_en <= 1'b1;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    // one read; data is taken once the answering edge has settled
    task automatic rd(input pscv_byte_t a, output pscv_byte_t d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_rd_en <= 1'b1;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        reg_addr  <= ~a;
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : pscv_host
`default_nettype wire

// ===== tb/pscv_top_bench.sv
// self-checking bench of the shutdown-cause and voltage-code bank
`timescale 1ns/1ps
`default_nettype none
module pscv_top_bench;
    import pscv_pkg::*;
    localparam logic [15:0] BF  = 16'h0190; // fine-range base, mV
    localparam logic [15:0] BW  = 16'h0258; // wide-range base, mV
    localparam logic [7:0]  C1R = 8'hE8;    // controller 1 factory value
    localparam logic [7:0]  C2R = 8'h64;    // controller 2 factory value
    logic       sys_clk = 1'b0;
    logic       rst_b   = 1'b0;
    pscv_byte_t addr, wdata, rdata;
    logic       wr_en, rd_en, sd_ind, sl1, dc1, sl2, dc2;
    logic       die_hot = 1'b0, uv = 1'b0, pf = 1'b0, pf_mask = 1'b0, ct = 1'b0;
    logic [15:0] rails  = 16'h0000; // faulting-rail pattern
    pscv_mv_t   mv1, mv2;
    int miscompares = 0;
    int n_compared  = 0;
    int cycles      = 0;
    int cause_m     = 0;            // model of the cause bits
    int reg_m[2]    = '{232, 100};  // model of both control registers
    always #10 sys_clk = ~sys_clk;
    pscv_top #(.CTRL1_RESET(C1R), .CTRL2_RESET(C2R), .WIDE_RANGE1(1'b0),
        .WIDE_RANGE2(1'b1), .BASE_FINE_MV(BF), .BASE_WIDE_MV(BW)) pscv_top_i (
        .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(addr), .reg_wr_en(wr_en),
        .reg_rd_en(rd_en), .reg_wdata(wdata), .reg_rdata(rdata),
        .die_hot_pin(die_hot), .uv_trip_pin(uv), .power_fault_cause_pin(pf),
        .power_fault_cause_mask_pin(pf_mask), .crit_temp_pin(ct), .fault_rail_pins(rails),
        .shutdown_indicator(sd_ind), .ctrl1_target_mv(mv1), .ctrl1_slew_down(sl1),
        .ctrl1_decay_down(dc1), .ctrl2_target_mv(mv2), .ctrl2_slew_down(sl2),
        .ctrl2_decay_down(dc2));
    pscv_host pscv_host_i (.sys_clk(sys_clk), .reg_addr(addr), .reg_wr_en(wr_en),
        .reg_rd_en(rd_en), .reg_wdata(wdata), .reg_rdata(rdata));
    // ****************************************************************
    // compare and stimulus tasks
    // ****************************************************************
    task automatic chk_out(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_out
    // register read compared with the model byte
    task automatic rdchk(input string nm, input pscv_byte_t a, input pscv_byte_t exp);
        pscv_byte_t d;
        pscv_host_i.rd(a, d);
        n_compared++;
        if (d !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, d);
        end
    endtask : rdchk
    // pulse one shutdown pin: 0 critical temp, 1 power fault, 2 undervoltage
    task automatic fire(input int k);
        @(posedge sys_clk);
        ct <= (k == 0);
        pf <= (k == 1);
        uv <= (k == 2);
        repeat (5) @(posedge sys_clk);
        ct <= 1'b0;
        pf <= 1'b0;
        uv <= 1'b0;
        repeat (4) @(posedge sys_clk);
        if (!(k == 1 && pf_mask))
            cause_m |= 1 << k;
    endtask : fire
    // write a control register, then check target, down-step flags and readback
    task automatic vid(input int c, input pscv_byte_t v);
        int oc;
        int nc;
        int mv;
        oc = reg_m[c] >> 1;
        nc = v >> 1;
        pscv_host_i.wr(c ? 8'h21 : 8'h20, v);
        reg_m[c] = v;
        repeat (3) @(posedge sys_clk);
        #1;
        mv = (c ? BW : BF) + nc * (c ? 25 : 10);
        chk_out("target", c ? mv2 : mv1, 16'(mv));
        chk_out("slew", c ? sl2 : sl1, 16'(nc < oc && !v[0]));
        chk_out("decay", c ? dc2 : dc1, 16'(nc < oc && v[0]));
        rdchk("ctrl", c ? 8'h21 : 8'h20, v);
    endtask : vid
    // closing report, the one place the run ends
    task automatic report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    // hang guard, well above the few hundred cycles the run needs
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            report_and_stop();
        end
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        void'($urandom(22308));
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        rdchk("cause", 8'h05, 8'(cause_m));
        rdchk("irq", 8'h02, 8'h00);
        rdchk("ctrl1", 8'h20, C1R);
        rdchk("ctrl2", 8'h21, C2R);
        chk_out("target1", mv1, BF + 16'(C1R[7:1]) * 16'h000A);
        chk_out("target2", mv2, BW + 16'(C2R[7:1]) * 16'h0019);
        // pins change on the clock edge, never a nanosecond after a read
        @(posedge sys_clk);
        die_hot <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rdchk("status", 8'h04, 8'h01);
        pscv_host_i.wr(8'h04, 8'hFE);
        die_hot <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rdchk("status", 8'h04, 8'h00);
        rdchk("unmapped", 8'h7E, 8'h00);
        // a masked power fault leaves no record
        @(posedge sys_clk);
        pf_mask <= 1'b1;
        fire(1);
        rdchk("masked", 8'h05, 8'(cause_m));
        chk_out("indicator", sd_ind, 16'h0000);
        @(posedge sys_clk);
        pf_mask <= 1'b0;
        rails   <= 16'($urandom);
        for (int k = 0; k < 3; k++)
        begin
            fire(k);
            rdchk("cause", 8'h05, 8'(cause_m));
            chk_out("indicator", sd_ind, 16'h0001);
        end
        rdchk("rail_lo", 8'hB2, rails[7:0]);
        rdchk("rail_hi", 8'hB3, rails[15:8]);
        // zeros keep, ones clear; the indicator waits for an empty cause register
        pscv_host_i.wr(8'h05, 8'h00);
        rdchk("cause", 8'h05, 8'(cause_m));
        pscv_host_i.wr(8'h02, 8'h08);
        rdchk("irq", 8'h02, 8'h08);
        pscv_host_i.wr(8'h05, 8'h02);
        cause_m &= ~2;
        rdchk("cause", 8'h05, 8'(cause_m));
        pscv_host_i.wr(8'h05, 8'hFF);
        cause_m &= ~255;
        rdchk("cause", 8'h05, 8'(cause_m));
        pscv_host_i.wr(8'h02, 8'h08);
        rdchk("irq", 8'h02, 8'h00);
        chk_out("indicator", sd_ind, 16'h0000);
        // directed down-steps with both decay settings, then random codes
        vid(0, 8'hFF);
        vid(0, 8'h01);
        vid(1, 8'hFE);
        vid(1, 8'h02);
        for (int i = 0; i < 12; i++)
            vid(i % 2, 8'($urandom));
        report_and_stop();
    end
endmodule : pscv_top_bench
`default_nettype wire
